// *** dbgci_pkg.sv ***
// dbgci_pkg: constants and carrier types of the debug command interpreter
// assumes a single 10 MHz system clock; link pins sampled in that domain
package dbgci_pkg;

   // instruction codes, command byte bits 7..3
   localparam logic [4:0] DBGCI_OP_ERASE = 5'h02;
   localparam logic [4:0] DBGCI_OP_WRCFG = 5'h03;
   localparam logic [4:0] DBGCI_OP_RDCFG = 5'h04;
   localparam logic [4:0] DBGCI_OP_PC = 5'h05;
   localparam logic [4:0] DBGCI_OP_STAT = 5'h06;
   localparam logic [4:0] DBGCI_OP_BRK = 5'h07;
   localparam logic [4:0] DBGCI_OP_HALT = 5'h08;
   localparam logic [4:0] DBGCI_OP_RESUME = 5'h09;
   localparam logic [4:0] DBGCI_OP_INJECT = 5'h0a;
   localparam logic [4:0] DBGCI_OP_STEP = 5'h0b;
   localparam logic [4:0] DBGCI_OP_SUBST = 5'h0c;
   localparam logic [4:0] DBGCI_OP_ID = 5'h0d;

   // command byte field positions
   localparam int DBGCI_CMD_OP_LSB = 3;
   localparam int DBGCI_CMD_RET_BIT = 2;

   // debug configuration byte bits
   localparam int DBGCI_CFG_INFO_BIT = 0;
   localparam int DBGCI_CFG_SUSP_BIT = 1;
   localparam int DBGCI_CFG_DMA_BIT = 2;
   localparam int DBGCI_CFG_TOFF_BIT = 3;
   localparam logic [7:0] DBGCI_CFG_RESET = 8'h00;

   // breakpoint first data byte fields
   localparam int DBGCI_BRK_NUM_LSB = 3;
   localparam int DBGCI_BRK_EN_BIT = 2;

   // identity value, arbitrary
   localparam logic [15:0] DBGCI_PART_ID = 16'h5a01;

   // serial sizes
   localparam logic [2:0] DBGCI_BIT_LAST = 3'h7;

   typedef enum logic [1:0] {
      DBGCI_RX_CMD,
      DBGCI_RX_DATA,
      DBGCI_TX
   } dbgci_phase_t;

   // actions sent to the cpu core; the strobes are one-cycle pulses, the operands hold their value
   typedef struct packed {
      logic halt;
      logic resume;
      logic inject;
      logic step;
      logic subst;
      logic erase;
      logic brk_set;
      logic [1:0] instr_len;
      logic [23:0] instr;
      logic [1:0] brk_num;
      logic brk_en;
      logic [17:0] brk_addr;
   } dbgci_act_t;

   // state coming back from the cpu core and flash
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] status;
      logic cpu_halted;
      logic lock_n;
   } dbgci_core_t;

   // controls driven from the configuration byte
   typedef struct packed {
      logic timers_off;
      logic timers_freeze;
      logic dma_pause;
      logic info_page;
   } dbgci_ctl_t;

endpackage

// *** dbgci_edge.sv ***
// dbgci_edge: two-flop synchroniser with edge detection for link pins
// assumes pins are asynchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module dbgci_edge (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // pin and results
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } dbgci_sync_t;

   dbgci_sync_t s_q;
   dbgci_sync_t s_d;

   always_comb begin
      s_d.meta = pin_i;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign level_o = s_q.sync;
   assign rise_o = s_q.sync & ~s_q.prev;
   assign fall_o = ~s_q.sync & s_q.prev;
endmodule // dbgci_edge
`default_nettype wire

// *** dbgci_top.sv ***
// dbgci_top: debug port command decoder with configuration byte
// assumes the core answers actions and reports pc, status, halted, lock
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - mass-erase command erases flash and clears lock bits
// - any accepted command besides status read disables mass erase
// - configuration write stores the following data byte
// - configuration read returns the byte last written
// - pc read returns two bytes regardless of return bit
// - status read returns the one-byte debug status
// - halt stops cpu; resume only accepted while halted
// - injected instruction runs supplied bytes; low bits give count
// - inject, step and substitute run only while cpu halted
// - single step executes next instruction then advances pc
// - substitute step runs supplied instruction then advances pc
// - identity read returns two bytes regardless of return bit
// - bit 3 disables timers, overriding the suspend bit
// - bit 2 pauses all dma transfers
// - bit 1 freezes timers during injected and branching steps
// - bit 0 selects information page, else main flash
// - command byte: code 7..3, return bit 2, count 1..0
// - drive on rising link clock, sample on falling, msb first
// - while locked only erase, status and identity are obeyed
// - breakpoint bytes: number, enable, address 17..16, then 15..0
module dbgci_top
   import dbgci_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // debug mode entry
   input wire logic dbg_enter_i,
   // debug link pins
   input wire logic dclk_i,
   input wire logic ddata_i,
   output logic ddata_o,
   output logic ddata_oe_n_o,
   // core side
   input wire dbgci_core_t core_i,
   output dbgci_act_t act_o,
   output dbgci_ctl_t ctl_o
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      dbgci_phase_t phase;
      logic [2:0] bitn;
      logic [7:0] shreg;
      logic [7:0] cmd;
      logic [1:0] left;
      logic [23:0] data;
      logic [15:0] tx;
      logic tx_two;
      logic erase_ok;
      logic [7:0] cfg;
      logic dout;
      logic oe_n;
      dbgci_act_t act;
      dbgci_ctl_t ctl;
   } dbgci_state_t;

   dbgci_state_t s_q;
   dbgci_state_t s_d;
   logic dclk_rise;
   logic dclk_fall;
   logic din;

   dbgci_edge u_clk (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .pin_i(dclk_i),
      .level_o(),
      .rise_o(dclk_rise),
      .fall_o(dclk_fall)
   );

   dbgci_edge u_dat (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .pin_i(ddata_i),
      .level_o(din),
      .rise_o(),
      .fall_o()
   );

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] byte_in;
   logic [4:0] op;
   logic locked;
   logic allowed;
   assign byte_in = {s_q.shreg[6:0], din};
   assign op = s_q.cmd[7:DBGCI_CMD_OP_LSB];
   assign locked = ~core_i.lock_n;
   // lock blocks all but erase, status and identity
   assign allowed = ~locked || op == DBGCI_OP_ERASE ||
      op == DBGCI_OP_STAT || op == DBGCI_OP_ID;

   always_comb begin
      s_d = s_q;
      s_d.act.halt = 1'b0;
      s_d.act.resume = 1'b0;
      s_d.act.inject = 1'b0;
      s_d.act.step = 1'b0;
      s_d.act.subst = 1'b0;
      s_d.act.erase = 1'b0;
      s_d.act.brk_set = 1'b0;

      if (dbg_enter_i) begin
         s_d.cfg = DBGCI_CFG_RESET;
         s_d.erase_ok = 1'b1;
         // drop any half-received command so it is not decoded later
         s_d.cmd = 8'h00;
         s_d.phase = DBGCI_RX_CMD;
         s_d.bitn = 3'h0;
         s_d.oe_n = 1'b1;
      end else begin
         case (s_q.phase)
            DBGCI_RX_CMD, DBGCI_RX_DATA: begin
               // sample on falling link clock, msb first
               if (dclk_fall) begin
                  s_d.shreg = byte_in;
                  s_d.bitn = s_q.bitn + 3'h1;
                  if (s_q.bitn == DBGCI_BIT_LAST) begin
                     if (s_q.phase == DBGCI_RX_CMD) begin
                        s_d.cmd = byte_in;
                        s_d.left = byte_in[1:0];
                        s_d.data = 24'h000000;
                        if (byte_in[1:0] != 2'h0) begin
                           s_d.phase = DBGCI_RX_DATA;
                        end
                     end else begin
                        s_d.data = {s_q.data[15:0], byte_in};
                        s_d.left = s_q.left - 2'h1;
                     end
                  end
               end
               // command complete: decode and act once
               if (s_q.phase == DBGCI_RX_DATA && s_q.left == 2'h0 ||
                   s_q.phase == DBGCI_RX_CMD && s_q.bitn == 3'h0 &&
                   s_q.cmd != 8'h00) begin
                  s_d.cmd = 8'h00;
                  s_d.phase = DBGCI_RX_CMD;
                  s_d.tx_two = 1'b0;
                  s_d.tx = {core_i.status, 8'h00};
                  if (op != DBGCI_OP_STAT) begin
                     s_d.erase_ok = 1'b0;
                  end
                  if (allowed) begin
                     case (op)
                        DBGCI_OP_ERASE:
                           s_d.act.erase = s_q.erase_ok;
                        DBGCI_OP_WRCFG:
                           s_d.cfg = s_q.data[7:0];
                        DBGCI_OP_RDCFG:
                           s_d.tx = {s_q.cfg, 8'h00};
                        DBGCI_OP_PC: begin
                           s_d.tx = core_i.pc;
                           s_d.tx_two = 1'b1;
                        end
                        DBGCI_OP_ID: begin
                           s_d.tx = DBGCI_PART_ID;
                           s_d.tx_two = 1'b1;
                        end
                        DBGCI_OP_BRK: begin
                           s_d.act.brk_set = 1'b1;
                           s_d.act.brk_num =
                              s_q.data[DBGCI_BRK_NUM_LSB+17 -: 2];
                           s_d.act.brk_en = s_q.data[DBGCI_BRK_EN_BIT+16];
                           s_d.act.brk_addr = s_q.data[17:0];
                        end
                        DBGCI_OP_HALT:
                           s_d.act.halt = 1'b1;
                        DBGCI_OP_RESUME:
                           s_d.act.resume = core_i.cpu_halted;
                        DBGCI_OP_INJECT: begin
                           s_d.act.inject = core_i.cpu_halted;
                           s_d.act.instr = s_q.data;
                           s_d.act.instr_len = s_q.cmd[1:0];
                        end
                        DBGCI_OP_STEP:
                           s_d.act.step = core_i.cpu_halted;
                        DBGCI_OP_SUBST: begin
                           s_d.act.subst = core_i.cpu_halted;
                           s_d.act.instr = s_q.data;
                           s_d.act.instr_len = s_q.cmd[1:0];
                        end
                        default: ;
                     endcase
                  end
                  if (s_q.cmd[DBGCI_CMD_RET_BIT] || ((op == DBGCI_OP_PC ||
                      op == DBGCI_OP_ID) && allowed)) begin
                     s_d.phase = DBGCI_TX;
                     s_d.bitn = 3'h0;
                  end
               end
            end
            DBGCI_TX: begin
               // drive on rising link clock, msb first
               if (dclk_rise) begin
                  s_d.oe_n = 1'b0;
                  s_d.dout = s_q.tx[15];
                  s_d.tx = {s_q.tx[14:0], 1'b0};
                  s_d.bitn = s_q.bitn + 3'h1;
               end
               if (dclk_fall && s_q.bitn == 3'h0 && !s_q.oe_n) begin
                  if (s_q.tx_two) begin
                     s_d.tx_two = 1'b0;
                  end else begin
                     s_d.phase = DBGCI_RX_CMD;
                     s_d.oe_n = 1'b1;
                  end
               end
            end
            default: s_d.phase = DBGCI_RX_CMD;
         endcase
      end

      // configuration outputs; upper bits are ignored
      s_d.ctl.timers_off = s_d.cfg[DBGCI_CFG_TOFF_BIT];
      s_d.ctl.timers_freeze = s_d.cfg[DBGCI_CFG_SUSP_BIT] &
         ~s_d.cfg[DBGCI_CFG_TOFF_BIT];
      s_d.ctl.dma_pause = s_d.cfg[DBGCI_CFG_DMA_BIT];
      s_d.ctl.info_page = s_d.cfg[DBGCI_CFG_INFO_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.erase_ok <= 1'b1;
         s_q.oe_n <= 1'b1;
         s_q.cfg <= DBGCI_CFG_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign ddata_o = s_q.dout;
   assign ddata_oe_n_o = s_q.oe_n;
   assign act_o = s_q.act;
   assign ctl_o = s_q.ctl;

endmodule // dbgci_top
`default_nettype wire

// *** dbgci_props.sv ***
// dbgci_props: port assertions for dbgci_top
// assumes one mclk_i domain, async active-high rst_i
`timescale 1ns/1ps
`default_nettype none
module dbgci_props
   import dbgci_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // watched ports
   input wire logic dbg_enter_i,
   input wire logic dclk_i,
   input wire logic ddata_i,
   input wire logic ddata_o,
   input wire logic ddata_oe_n_o,
   input wire dbgci_core_t core_i,
   input wire dbgci_act_t act_o,
   input wire dbgci_ctl_t ctl_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic used_q;
   logic run;
   assign run = act_o.halt | act_o.resume | act_o.inject | act_o.step |
      act_o.subst | act_o.brk_set;
   // set once a halt, resume, inject, step, substitute or breakpoint action has fired since debug entry
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) used_q <= 1'b0;
      else if (dbg_enter_i) used_q <= 1'b0;
      else if (run) used_q <= 1'b1;
   end
   ////////////////////////////////////////
   chk_freeze_mask: assert property (
      ctl_o.timers_freeze |-> !ctl_o.timers_off)
      else $error("timer freeze with timers off");
   chk_resume_halted: assert property (
      act_o.resume |-> $past(core_i.cpu_halted))
      else $error("resume while running");
   chk_step_halted: assert property (
      act_o.inject | act_o.step | act_o.subst |-> $past(core_i.cpu_halted))
      else $error("step action while running");
   chk_locked_idle: assert property (
      !$past(core_i.lock_n) |-> !run)
      else $error("action while locked");
   chk_locked_cfg: assert property (
      !core_i.lock_n && !dbg_enter_i && !$past(dbg_enter_i)
      |=> $stable(ctl_o))
      else $error("config changed while locked");
   chk_drive_rise: assert property (
      $fell(ddata_oe_n_o) |-> $past(dclk_i, 2))
      else $error("drive not after clock rise");
   chk_erase_armed: assert property (
      act_o.erase |-> !used_q)
      else $error("erase after other command");
   chk_enter_clear: assert property (
      dbg_enter_i |-> ##2 (ctl_o == '0))
      else $error("config not cleared on entry");
   chk_halt_pulse: assert property (
      act_o.halt |=> !act_o.halt)
      else $error("halt pulse too long");
   cover property (act_o.erase);
   cover property (act_o.inject);
   cover property (!ddata_oe_n_o);
   cover property (ctl_o.timers_freeze);
endmodule // dbgci_props
bind dbgci_top dbgci_props i_props (.mclk_i, .rst_i, .dbg_enter_i,
   .dclk_i, .ddata_i, .ddata_o, .ddata_oe_n_o, .core_i, .act_o, .ctl_o);
`default_nettype wire

// *** dbgci_host.sv ***
// dbgci_host: debug host model driving the two-wire link
// assumes an 800 ns link period built from mclk_i edges
`timescale 1ns/1ps
`default_nettype none
module dbgci_host (
   // clock
   input wire logic mclk_i,
   // link
   output logic dclk_o,
   output logic ddata_o,
   output logic ddata_oe_n_o,
   input wire logic wire_i
);
   initial begin
      dclk_o = 1'b0;
      ddata_o = 1'b0;
      ddata_oe_n_o = 1'b1;
   end
   // drive each bit on the rise, msb first
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge mclk_i);
         dclk_o <= 1'b1;
         ddata_oe_n_o <= 1'b0;
         ddata_o <= b[i];
         repeat (4) @(posedge mclk_i);
         dclk_o <= 1'b0;
         repeat (3) @(posedge mclk_i);
      end
   endtask
   // release the line, sample after each fall
   task automatic get_bits(input int n, output logic [23:0] v);
      v = '0;
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_i);
         dclk_o <= 1'b1;
         ddata_oe_n_o <= 1'b1;
         repeat (4) @(posedge mclk_i);
         dclk_o <= 1'b0;
         repeat (2) @(posedge mclk_i);
         v = {v[22:0], wire_i};
         @(posedge mclk_i);
      end
   endtask
endmodule // dbgci_host
`default_nettype wire

// *** tb_dbgci_top.sv ***
// tb_dbgci_top: self-checking bench for the debug command decoder
// assumes dbgci_host as link partner and a 10 MHz mclk_i
`timescale 1ns/1ps
`default_nettype none
module tb_dbgci_top;
   import dbgci_pkg::*;
   logic mclk_i, rst_i, dbg_enter_i, clr;
   logic dclk, h_data, h_oe_n, d_data, d_oe_n, line;
   dbgci_core_t core;
   dbgci_act_t act;
   dbgci_ctl_t ctl;
   logic [23:0] seen, rd;
   int num_errors = 0;
   int check_count = 0;
   // device wins, then host, else pull-up
   assign line = !d_oe_n ? d_data : (!h_oe_n ? h_data : 1'b1);
   dbgci_top i_dut (.mclk_i, .rst_i, .dbg_enter_i, .dclk_i(dclk),
      .ddata_i(line), .ddata_o(d_data), .ddata_oe_n_o(d_oe_n),
      .core_i(core), .act_o(act), .ctl_o(ctl));
   dbgci_host i_host (.mclk_i, .dclk_o(dclk), .ddata_o(h_data),
      .ddata_oe_n_o(h_oe_n), .wire_i(line));
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      if (clr || rst_i) seen <= '0;
      else seen <= seen | {17'h0, act.halt, act.resume, act.inject,
         act.step, act.subst, act.erase, act.brk_set};
   end
   ////////////////////////////////////////
   task automatic check(input string s, input logic [23:0] e, g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask
   // command with its data bytes, msb byte first
   task automatic act_chk(input logic [7:0] c, input logic [23:0] d, e);
      clr <= 1'b1;
      @(posedge mclk_i);
      clr <= 1'b0;
      i_host.put_byte(c);
      for (int i = 1; i <= int'(c[1:0]); i++)
         i_host.put_byte(d[8 * (int'(c[1:0]) - i) +: 8]);
      // a set return bit makes the device answer with the status byte
      if (c[2]) begin
         i_host.get_bits(8, rd);
         check("return byte", {16'h0, core.status}, rd);
      end
      repeat (6) @(posedge mclk_i);
      check("actions", e, seen);
   endtask
   task automatic rd_chk(input logic [7:0] c, input int n,
      input logic [23:0] e);
      i_host.put_byte(c);
      i_host.get_bits(n, rd);
      check("read byte", e, rd);
      repeat (4) @(posedge mclk_i);
   endtask
   task automatic cfg_chk(input logic [7:0] v, input logic [3:0] e);
      act_chk(8'h19, {16'h0, v}, '0);
      check("controls", {20'h0, e}, 24'(ctl));
      rd_chk(8'h24, 8, {16'h0, v});
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      num_errors++;
      conclude();
   end
   initial begin
      rst_i = 1'b1;
      dbg_enter_i = 1'b0;
      clr = 1'b0;
      core = {16'hbeef, 8'ha5, 1'b0, 1'b0};
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      check("reset controls", '0, 24'(ctl));
      $display("test reset done");
      act_chk(8'h10, '0, 24'h02);
      rd_chk(8'h34, 8, 24'ha5);
      act_chk(8'h44, '0, '0);
      act_chk(8'h19, 24'h0f, '0);
      check("locked controls", '0, 24'(ctl));
      rd_chk(8'h68, 16, {8'h0, DBGCI_PART_ID});
      $display("test locked done");
      core.lock_n <= 1'b1;
      act_chk(8'h4c, '0, '0);
      act_chk(8'h55, 24'h77, '0);
      act_chk(8'h44, '0, 24'h40);
      act_chk(8'h10, '0, '0);
      core.cpu_halted <= 1'b1;
      act_chk(8'h4c, '0, 24'h20);
      act_chk(8'h57, 24'h123456, 24'h10);
      check("instr", 24'h123456, act.instr);
      act_chk(8'h5c, '0, 24'h08);
      act_chk(8'h65, 24'h9a, 24'h04);
      check("length", 24'h1, 24'(act.instr_len));
      act_chk(8'h3f, 24'h1dabcd, 24'h01);
      check("breakpoint", {3'h0, 2'h3, 1'b1, 18'h1abcd},
         24'({act.brk_num, act.brk_en, act.brk_addr}));
      rd_chk(8'h28, 16, 24'hbeef);
      $display("test commands done");
      cfg_chk(8'h0f, 4'hb);
      cfg_chk(8'h02, 4'h4);
      cfg_chk(8'h05, 4'h3);
      act_chk(8'h7a, 24'h3c3c, '0);
      rd_chk(8'h34, 8, 24'ha5);
      @(posedge mclk_i);
      dbg_enter_i <= 1'b1;
      @(posedge mclk_i);
      dbg_enter_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      check("entry controls", '0, 24'(ctl));
      act_chk(8'h10, '0, 24'h02);
      $display("test config done");
      conclude();
   end
endmodule // tb_dbgci_top
`default_nettype wire
